// file: src/admbc_pkg.sv
// Package for the converter module bus control block.
// Assumes a 25 MHz system clock and an 8-bit, 16-address-line processor bus.
package admbc_pkg;

	// Register offsets from the base address
	localparam logic [1:0] OFF_GAIN_MUX = 2'h0;
	localparam logic [1:0] OFF_CMD_STAT = 2'h1;
	localparam logic [1:0] OFF_DATA_HI  = 2'h2;
	localparam logic [1:0] OFF_DATA_LO  = 2'h3;

	// Gain and mux register fields
	localparam int GAIN_LSB = 6;
	localparam int CHAN_W   = 5;

	// Command register fields
	localparam int CMD_SOFT_START = 0;
	localparam int CMD_EXT_TRIG   = 1;
	localparam int CMD_HALT_EN    = 2;
	localparam int CMD_IRQ_EN     = 3;

	// Status register fields
	localparam int STAT_BUSY = 7;
	localparam int STAT_DONE = 6;

	// Values after reset
	localparam logic [7:0] GAIN_MUX_RST = 8'h00;
	localparam logic [3:0] MODE_RST     = 4'h0;

	// Base address range accepted
	localparam logic [15:0] BASE_MIN = 16'h0500;
	localparam logic [15:0] BASE_MAX = 16'hFD1C;

	// Conversion time and its cycle count at 25 MHz
	localparam int CONV_TIME_NS = 40_000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CONV_CYCLES  = CONV_TIME_NS / CLK_PERIOD_NS;

	// Converter sequencing states
	typedef enum logic [1:0] {ADMBC_IDLE, ADMBC_START, ADMBC_WAIT} admbc_state_t;

endpackage

// file: src/admbc_addr_decode.sv
// Base address comparator for the converter module.
// Assumes the straps are static levels; the address comes from bus flops.
`timescale 1ns/1ps
`default_nettype none

module admbc_addr_decode (
	// Bus address
	input  wire logic [15:0] busAddr,
	// Strap levels for A15..A11 and A4..A2
	input  wire logic [7:0]  baseStrap,
	// Result
	output logic             hit,
	output logic [1:0]       regSel
);

	logic [7:0] decodedBits;

	always_comb begin
		decodedBits = {busAddr[15:11], busAddr[4:2]};
		// A5..A10 must be zero so that all of A15..A2 take part in the decode
		hit = (decodedBits == baseStrap) && (busAddr[10:5] == 6'h00);
		regSel = busAddr[1:0];
	end

endmodule

`default_nettype wire

// file: src/admbc_top.sv
// Control and bus logic of a 12-bit multichannel analog-to-digital module.
// Assumes the processor bus is synchronous to sys_clk; trigger and converter
// done are asynchronous pins and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

module admbc_top #(
	parameter int CHANNELS = 16
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Processor bus
	input  wire logic [15:0] busAddr,
	input  wire logic [7:0]  busWrData,
	input  wire logic        busWrEn,
	input  wire logic        busRdEn,
	output logic [7:0]       busRdData,
	output logic             busSel,
	// Straps
	input  wire logic [7:0]  baseStrap,
	input  wire logic        twosCompStrap,
	input  wire logic        diffStrap,
	// Converter pins
	input  wire logic        extTrigger,
	input  wire logic        convDone,
	input  wire logic [11:0] convData,
	output logic             convStart,
	output logic [4:0]       muxChannel,
	output logic [1:0]       gainSel,
	// Processor control
	output logic             haltReq,
	output logic             irqReq
);

	////////////////////////////////////////////////////////////////////////
	// Address decode

	logic       hit;
	logic [1:0] regSel;
	logic       baseOk;

	admbc_addr_decode u_dec (
		.busAddr   (busAddr),
		.baseStrap (baseStrap),
		.hit       (hit),
		.regSel    (regSel)
	);

	logic [15:0] strapBase;

	// Base the straps select, with the lines that take no strap at zero
	assign strapBase = {baseStrap[7:3], 6'h00, baseStrap[2:0], 2'b00};
	// A strap set outside the legal window never answers
	assign baseOk = (strapBase >= admbc_pkg::BASE_MIN)
		&& (strapBase <= admbc_pkg::BASE_MAX);
	assign busSel = hit && baseOk;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	logic [1:0] pinRaw;
	logic [1:0] pinRise;

	// Bit 0 is the trigger pin, bit 1 the converter done pin
	assign pinRaw = {convDone, extTrigger};

	// Two flops against metastability; the third only keeps the last level
	for (genvar p = 0; p < 2; p++) begin : g_pin
		logic stage1_q, stage1_d;
		logic stage2_q, stage2_d;
		logic stage3_q, stage3_d;

		always_comb begin
			stage1_d = pinRaw[p];
			stage2_d = stage1_q;
			stage3_d = stage2_q;
		end

		always_ff @(posedge sys_clk) begin
			if (!rst_n) begin
				stage1_q <= 1'b0;
				stage2_q <= 1'b0;
				stage3_q <= 1'b0;
			end else begin
				stage1_q <= stage1_d;
				stage2_q <= stage2_d;
				stage3_q <= stage3_d;
			end
		end

		assign pinRise[p] = stage2_q && !stage3_q;
	end

	logic trigRise;
	logic doneRise;

	assign trigRise = pinRise[0];
	assign doneRise = pinRise[1];

	////////////////////////////////////////////////////////////////////////
	// Registers and conversion sequencing

	logic [7:0]               gainMux_q, gainMux_d;
	logic [3:0]               mode_q, mode_d;
	logic [11:0]              result_q, result_d;
	logic                     busy_q, busy_d;
	logic                     done_q, done_d;
	logic                     irq_q, irq_d;
	logic                     halt_q, halt_d;
	logic                     start_q, start_d;
	logic [15:0]              timer_q, timer_d;
	admbc_pkg::admbc_state_t  state_q, state_d;

	logic wrHit;
	logic rdHit;
	logic swStart;
	logic startReq;
	logic finish;
	logic [11:0] coded;

	assign wrHit = busSel && busWrEn;
	assign rdHit = busSel && busRdEn;
	assign swStart = wrHit && (regSel == admbc_pkg::OFF_CMD_STAT)
		&& busWrData[admbc_pkg::CMD_SOFT_START];
	// External trigger only counts when its mode bit is set
	assign startReq = mode_q[admbc_pkg::CMD_EXT_TRIG] ? trigRise : swStart;
	// Converter done pin, or the timeout if the converter never answers
	assign finish = doneRise || (timer_q == 16'(admbc_pkg::CONV_CYCLES));
	// Strap flips the MSB for offset binary to two's complement
	assign coded = twosCompStrap ? {~convData[11], convData[10:0]} : convData;

	////////////////////////////////////////////////////////////////////////
	// Channel, gain and mode registers

	localparam logic [4:0] CHAN_MASK = 5'((CHANNELS > 16) ? 31 : 15);

	logic [4:0] chanLimit;
	logic [4:0] muxChan_q, muxChan_d;

	// Differential strap halves the channel count
	assign chanLimit = diffStrap ? (CHAN_MASK >> 1) : CHAN_MASK;

	always_comb begin
		gainMux_d = gainMux_q;
		mode_d    = mode_q;
		if (wrHit && regSel == admbc_pkg::OFF_GAIN_MUX) begin
			gainMux_d = busWrData;
		end
		if (wrHit && regSel == admbc_pkg::OFF_CMD_STAT) begin
			mode_d = busWrData[3:0];
		end
		// Registered so the analog multiplexer never sees a decode glitch
		muxChan_d = gainMux_d[admbc_pkg::CHAN_W-1:0] & chanLimit;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gainMux_q <= admbc_pkg::GAIN_MUX_RST;
			mode_q    <= admbc_pkg::MODE_RST;
			muxChan_q <= 5'h00;
		end else begin
			gainMux_q <= gainMux_d;
			mode_q    <= mode_d;
			muxChan_q <= muxChan_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion timer

	// Runs from the start pulse so a silent converter still ends the wait
	always_comb begin
		timer_d = timer_q;
		if (state_q != admbc_pkg::ADMBC_IDLE) begin
			timer_d = timer_q + 16'h0001;
		end else if (startReq) begin
			timer_d = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			timer_q <= 16'h0000;
		end else begin
			timer_q <= timer_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion sequencing

	// A start while busy is ignored: only the idle state looks at startReq
	always_comb begin
		result_d  = result_q;
		busy_d    = busy_q;
		done_d    = done_q;
		irq_d     = irq_q;
		halt_d    = halt_q;
		start_d   = 1'b0;
		state_d   = state_q;

		// Status read clears done and interrupt; a new finish below wins
		if (rdHit && regSel == admbc_pkg::OFF_CMD_STAT) begin
			done_d = 1'b0;
			irq_d  = 1'b0;
		end

		unique case (state_q)
			admbc_pkg::ADMBC_IDLE: begin
				if (startReq) begin
					start_d = 1'b1;
					busy_d  = 1'b1;
					halt_d  = mode_d[admbc_pkg::CMD_HALT_EN];
					state_d = admbc_pkg::ADMBC_START;
				end
			end
			admbc_pkg::ADMBC_START: begin
				state_d = admbc_pkg::ADMBC_WAIT;
			end
			admbc_pkg::ADMBC_WAIT: begin
				if (finish) begin
					result_d = coded;
					busy_d   = 1'b0;
					done_d   = 1'b1;
					halt_d   = 1'b0;
					irq_d    = mode_q[admbc_pkg::CMD_IRQ_EN];
					state_d  = admbc_pkg::ADMBC_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			result_q  <= 12'h000;
			busy_q    <= 1'b0;
			done_q    <= 1'b0;
			irq_q     <= 1'b0;
			halt_q    <= 1'b0;
			start_q   <= 1'b0;
			state_q   <= admbc_pkg::ADMBC_IDLE;
		end else begin
			result_q  <= result_d;
			busy_q    <= busy_d;
			done_q    <= done_d;
			irq_q     <= irq_d;
			halt_q    <= halt_d;
			start_q   <= start_d;
			state_q   <= state_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign muxChannel = muxChan_q;
	assign gainSel   = gainMux_q[admbc_pkg::GAIN_LSB +: 2];
	assign convStart = start_q;
	assign haltReq   = halt_q;
	assign irqReq    = irq_q;

	logic [7:0] rdMux_q, rdMux_d;

	always_comb begin
		unique case (regSel)
			admbc_pkg::OFF_GAIN_MUX: rdMux_d = gainMux_q;
			admbc_pkg::OFF_CMD_STAT: rdMux_d = {busy_q, done_q, 2'b00, mode_q};
			admbc_pkg::OFF_DATA_HI:  rdMux_d = {4'h0, result_q[11:8]};
			admbc_pkg::OFF_DATA_LO:  rdMux_d = result_q[7:0];
		endcase
		if (!rdHit) begin
			rdMux_d = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rdMux_q <= 8'h00;
		end else begin
			rdMux_q <= rdMux_d;
		end
	end

	assign busRdData = rdMux_q;

endmodule

`default_nettype wire

// file: verif/admbc_conv_model.sv
// Converter model: raises done a set number of cycles after each start.
// Assumes convStart is a one-cycle pulse; a delay of 0 never finishes.
`timescale 1ns/1ps
`default_nettype none
module admbc_conv_model #(
	parameter logic [11:0] RESULT = 12'h000
) (
	// Clock and start
	input  wire logic        sys_clk,
	input  wire logic        convStart,
	input  wire logic [15:0] delay,
	// Answer
	output logic             convDone,
	output logic [11:0]      convData
);
	logic [15:0] cnt = 16'h0000;
	initial {convDone, convData} = 13'h0000;
	always @(posedge sys_clk) begin
		if (convStart) begin
			convDone <= 1'b0;
			// Data is inverted at each start, so an early sample shows up
			convData <= ~convData;
			cnt <= delay;
		end else if (cnt == 16'h0001) begin
			convDone <= 1'b1;
			convData <= RESULT;
		end
		if (!convStart && cnt != 16'h0000)
			cnt <= cnt - 16'h0001;
	end
endmodule
`default_nettype wire

// file: verif/admbc_checker.sv
// Checker for admbc_top: decode, reads, starts, halt and interrupt.
// Assumes it sees only the top ports, through the bind below.
`timescale 1ns/1ps
`default_nettype none
module admbc_checker (
	// Clock, reset and bus
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] busAddr,
	input  wire logic [7:0]  busWrData,
	input  wire logic        busWrEn,
	input  wire logic        busRdEn,
	input  wire logic [7:0]  busRdData,
	input  wire logic        busSel,
	input  wire logic [7:0]  baseStrap,
	// Converter and processor control
	input  wire logic        convStart,
	input  wire logic [4:0]  muxChannel,
	input  wire logic [1:0]  gainSel,
	input  wire logic        haltReq,
	input  wire logic        irqReq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	logic [3:0]  modeQ, modeD;
	logic [10:0] holdQ, holdD;
	wire  logic  wrHit = busSel && busWrEn;
	always_comb begin
		modeD = (wrHit && busAddr[1:0] == 2'h1) ? busWrData[3:0] : modeQ;
		holdD = haltReq ? holdQ + 11'h001 : 11'h000;
	end
	always_ff @(posedge sys_clk) begin
		modeQ <= rst_n ? modeD : 4'h0;
		holdQ <= rst_n ? holdD : 11'h000;
	end
	sequence rdOff(off);
		busSel && busRdEn && busAddr[1:0] == off;
	endsequence
	////////////////////////////////////////
	sel_hit_a: assert property (busSel |-> {busAddr[15:11], busAddr[4:2]} == baseStrap
		&& busAddr[10:5] == 6'h00 && baseStrap[7:3] != 5'h00)
		else $error("select off base");
	rd_idle_a: assert property (!(busSel && busRdEn) |=> busRdData == 8'h00)
		else $error("read data not idle");
	gain_set_a: assert property (wrHit && busAddr[1:0] == 2'h0 |=>
		{gainSel, muxChannel} == {$past(busWrData[7:6]), $past(busWrData[4:0])})
		else $error("gain not taken");
	start_gap_a: assert property (convStart |=> !convStart [*3])
		else $error("start repeated");
	halt_on_a: assert property (convStart && modeQ[2] |-> ##[0:1] haltReq)
		else $error("no halt at start");
	halt_max_a: assert property (holdQ <= 11'h3F2)
		else $error("halt too long");
	irq_mode_a: assert property ($rose(irqReq) |-> modeQ[3])
		else $error("irq without mode");
	irq_clr_a: assert property (irqReq ##0 rdOff(2'h1) |=> !irqReq)
		else $error("irq not cleared");
endmodule
bind admbc_top admbc_checker i_chk (.sys_clk, .rst_n, .busAddr, .busWrData, .busWrEn,
	.busRdEn, .busRdData, .busSel, .baseStrap, .convStart, .muxChannel, .gainSel,
	.haltReq, .irqReq);
`default_nettype wire

// file: verif/admbc_top_tb.sv
// Testbench for admbc_top with a converter model on its far side.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module admbc_top_tb;
	localparam logic [15:0] BASE = 16'h8004;
	localparam logic [11:0] RES  = 12'hA5C;
	logic        sys_clk = 1'b0, rst_n = 1'b0, busWrEn = 1'b0, busRdEn = 1'b0, busSel;
	logic        twos = 1'b0, extTrigger = 1'b0, convDone, convStart, haltReq, irqReq;
	logic        diff = 1'b0;
	logic [15:0] busAddr = BASE, dly = 16'h0014;
	logic [7:0]  busWrData = 8'h00, busRdData, strap = 8'h81;
	logic [11:0] convData;
	logic [4:0]  muxChannel;
	logic [1:0]  gainSel;
	int          n_mismatch = 0, n_checks = 0, cyc = 0, i;
	always #20 sys_clk = ~sys_clk;
	admbc_top #(.CHANNELS(32)) i_dut (.sys_clk, .rst_n, .busAddr, .busWrData, .busWrEn,
		.busRdEn, .busRdData, .busSel, .baseStrap(strap), .twosCompStrap(twos),
		.diffStrap(diff), .extTrigger, .convDone, .convData, .convStart, .muxChannel,
		.gainSel, .haltReq, .irqReq);
	admbc_conv_model #(.RESULT(RES)) i_conv (.sys_clk, .convStart, .delay(dly),
		.convDone, .convData);
	////////////////////////////////////////
	task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWrData <= d;
		busWrEn <= 1'b1;
		@(posedge sys_clk);
		busWrEn <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [1:0] off, input logic [7:0] exp, input string n);
		@(posedge sys_clk);
		busAddr <= BASE | {14'h0000, off};
		busRdEn <= 1'b1;
		@(posedge sys_clk);
		busRdEn <= 1'b0;
		#1 chk(n, {4'h0, busRdData}, {4'h0, exp});
	endtask
	task automatic waitIdle;
		for (i = 0; i < 1200 && haltReq !== 1'b0; i++) @(negedge sys_clk);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		rd(2'h0, 8'h00, "gain");
		rd(2'h1, 8'h00, "status");
		for (int g = 0; g < 4; g++) begin
			wr(BASE, {g[1:0], 6'h13});
			chk("gainSel", {10'h000, gainSel}, g[11:0]);
			chk("channel", {7'h00, muxChannel}, 12'h013);
			rd(2'h0, {g[1:0], 6'h13}, "gain");
		end
		chk("selected", {11'h000, busSel}, 12'h001);
		// Differential strap halves the channel field on the next edge
		diff <= 1'b1;
		@(posedge sys_clk);
		#1 chk("diffChan", {7'h00, muxChannel}, 12'h003);
		diff <= 1'b0;
		wr(BASE | 16'h0800, 8'h00);
		wr(BASE | 16'h0010, 8'h00);
		chk("foreign", {10'h000, gainSel}, 12'h003);
		chk("unselected", {11'h000, busSel}, 12'h000);
		// Base 0014 matches its straps but lies below the legal window
		strap <= 8'h05;
		wr(16'h0014, 8'h00);
		chk("lowBase", {11'h000, busSel}, 12'h000);
		chk("lowBaseGain", {10'h000, gainSel}, 12'h003);
		strap <= 8'h81;
		wr(BASE + 16'h0001, 8'h0C);
		rd(2'h1, 8'h0C, "mode");
		wr(BASE + 16'h0001, 8'h0D);
		rd(2'h1, 8'h8D, "busy");
		waitIdle();
		chk("irq", {11'h000, irqReq}, 12'h001);
		rd(2'h2, {4'h0, RES[11:8]}, "high");
		rd(2'h3, RES[7:0], "low");
		rd(2'h1, 8'h4D, "done");
		chk("irqClr", {11'h000, irqReq}, 12'h000);
		twos <= 1'b1;
		wr(BASE + 16'h0001, 8'h06);
		extTrigger <= 1'b1;
		for (i = 0; i < 20 && convStart !== 1'b1; i++) @(negedge sys_clk);
		chk("extStart", {11'h000, convStart}, 12'h001);
		extTrigger <= 1'b0;
		repeat (2) @(negedge sys_clk);
		waitIdle();
		rd(2'h2, 8'h02, "twos");
		twos <= 1'b0;
		dly = 16'h0000;
		// Leave trigger mode first: the start bit counts under the old mode
		wr(BASE + 16'h0001, 8'h04);
		wr(BASE + 16'h0001, 8'h05);
		repeat (900) @(posedge sys_clk);
		#1 chk("held", {11'h000, haltReq}, 12'h001);
		waitIdle();
		chk("freed", {11'h000, haltReq}, 12'h000);
		rd(2'h2, 8'h05, "timeout");
		print_verdict();
	end
endmodule
`default_nettype wire
